// ===== rtl/ivpm_params.svh
// constants of the interrupt vector priority map
`ifndef IVPM_PARAMS_SVH
`define IVPM_PARAMS_SVH

`define IVPM_NUM_SRC 37
`define IVPM_IDX_W 6
`define IVPM_VEC_W 7
`define IVPM_ADDR_W 24
`define IVPM_NMI_VEC 7'h07

`define IVPM_OFF_LEVEL_A 8'h00
`define IVPM_OFF_LEVEL_B 8'h04
`define IVPM_OFF_LEVEL_C 8'h08
`define IVPM_OFF_CTRL 8'h0c
`define IVPM_OFF_STATUS 8'h10
`define IVPM_OFF_MASK 8'h14
`define IVPM_OFF_VECTOR 8'h18

`define IVPM_CTRL_ADV_BIT 0
`define IVPM_STAT_NEWVEC_BIT 0
`define IVPM_STAT_NMI_BIT 1
`define IVPM_STAT_W 2
`define IVPM_VEC_VALID_BIT 7
`define IVPM_LVL_RESET 8'h00

// level bit position per source: a = 0..7, b = 8..15, c = 16..23
`define IVPM_LVL_NONE 5'd31
`define IVPM_LVL_ALWAYS 5'd30
`define IVPM_LVL_TABLE { \
   5'd19, 5'd20, 5'd20, 5'd22, 5'd22, 5'd22, 5'd22, 5'd23, 5'd23, 5'd23, \
   5'd23, 5'd9, 5'd9, 5'd9, 5'd9, 5'd10, 5'd10, 5'd10, 5'd11, 5'd11, \
   5'd11, 5'd14, 5'd14, 5'd14, 5'd14, 5'd14, 5'd14, 5'd14, 5'd15, 5'd31, \
   5'd0, 5'd1, 5'd2, 5'd5, 5'd6, 5'd7, 5'd30}

// vector number per source, source 0 in the low bits
`define IVPM_VEC_TABLE { \
   7'd94, 7'd93, 7'd92, 7'd87, 7'd86, 7'd85, 7'd84, 7'd83, 7'd82, 7'd81, \
   7'd80, 7'd75, 7'd74, 7'd73, 7'd72, 7'd70, 7'd69, 7'd68, 7'd66, 7'd65, \
   7'd64, 7'd54, 7'd53, 7'd52, 7'd51, 7'd50, 7'd49, 7'd48, 7'd28, 7'd27, \
   7'd26, 7'd25, 7'd24, 7'd18, 7'd17, 7'd16, 7'd7}

`endif

// ===== rtl/ivpm_pick.sv
// lowest-index set bit finder
`default_nettype none
module ivpm_pick
#(
   parameter int N = 37,
   parameter int IW = 6
)
(
   input wire logic [N-1:0] req,
   output logic found,
   output logic [IW-1:0] idx
);

   // scan from the top so the lowest set index is left standing
   always_comb
   begin
      found = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            found = 1'b1;
            idx = IW'(i);
         end
      end
   end

endmodule : ivpm_pick
`default_nettype wire

// ===== rtl/ivpm_pkg.sv
// types of the interrupt vector priority map
`default_nettype none
package ivpm_pkg;

   // on-chip requests; last field is source 4 (vector 24)
   typedef struct packed {
      logic twowire1_byte_req;
      logic twowire0_format_switch_req;
      logic twowire0_byte_req;
      logic ser1_tx_end_req;
      logic ser1_tx_empty_req;
      logic ser1_rx_full_req;
      logic ser1_rx_error_req;
      logic ser0_tx_end_req;
      logic ser0_tx_empty_req;
      logic ser0_rx_full_req;
      logic ser0_rx_error_req;
      logic tmrx_capture_req;
      logic tmry_overflow_req;
      logic tmry_match_b_req;
      logic tmry_match_a_req;
      logic tmr1_overflow_req;
      logic tmr1_match_b_req;
      logic tmr1_match_a_req;
      logic tmr0_overflow_req;
      logic tmr0_match_b_req;
      logic tmr0_match_a_req;
      logic frt_overflow_req;
      logic frt_compare_b_req;
      logic frt_compare_a_req;
      logic frt_capture_d_req;
      logic frt_capture_c_req;
      logic frt_capture_b_req;
      logic frt_capture_a_req;
      logic converter_done_req;
      logic addr_break_req;
      logic wdog1_interval_req;
      logic wdog0_interval_req;
      logic xfer_sw_activation_done;
   } ivpm_req_type;

   typedef struct packed {
      logic valid;
      logic [6:0] num;
      logic [23:0] addr;
   } ivpm_vec_type;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RDWAIT = 2'b10
   } ivpm_bus_state_type;

endpackage : ivpm_pkg
`default_nettype wire

// ===== rtl/ivpm_top.sv
// interrupt vector priority map with its register slave
`include "ivpm_params.svh"
`default_nettype none
module ivpm_top
   import ivpm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic nmi_pin,
   input wire logic [2:0] irq_pin,
   input wire ivpm_req_type periph_req,
   output ivpm_vec_type vec_out,
   output logic irq
);

   localparam int NS = `IVPM_NUM_SRC;
   localparam int IW = `IVPM_IDX_W;
   localparam logic [NS*5-1:0] LVL_TAB = `IVPM_LVL_TABLE;
   localparam logic [NS*7-1:0] VEC_TAB = `IVPM_VEC_TABLE;

   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;
   logic nmi_prev_q;
   logic [NS-1:0] req_v;
   logic [NS-1:0] lvl_v;
   logic [NS-1:0] hi_req;
   logic [NS-1:0] cand;
   logic found;
   logic [IW-1:0] pick_idx;
   logic [6:0] vec_num_c;
   logic [23:0] addr_c;
   logic [7:0] lvl_a_q;
   logic [7:0] lvl_b_q;
   logic [7:0] lvl_c_q;
   logic [23:0] lvl_all;
   logic adv_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [1:0] status_d;
   logic new_vec_ev;
   logic nmi_ev;
   logic irq_q;
   ivpm_vec_type vec_q;
   ivpm_bus_state_type bus_q;
   logic accept;
   logic wr_pend_q;
   logic [7:0] addr_q;
   logic hready_q;
   logic hresp_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;

   assign hrdata = hrdata_q;
   assign hreadyout = hready_q;
   assign hresp = hresp_q;
   assign vec_out = vec_q;
   assign irq = irq_q;

   // pin requests cross in through two flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta_q <= 4'h0;
         pin_sync_q <= 4'h0;
         nmi_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_meta_q <= {irq_pin, nmi_pin};
         pin_sync_q <= pin_meta_q;
         nmi_prev_q <= pin_sync_q[0];
      end
   end

   // source i sits at bit i, ordered by vector number
   assign req_v = {periph_req, pin_sync_q};
   assign lvl_all = {lvl_c_q, lvl_b_q, lvl_a_q};

   for (genvar g = 0; g < NS; g++)
   begin : g_lvl
      localparam logic [4:0] POS = LVL_TAB[g*5 +: 5];
      if (POS == `IVPM_LVL_ALWAYS)
      begin : g_top
         assign lvl_v[g] = 1'b1;
      end
      else if (POS == `IVPM_LVL_NONE)
      begin : g_none
         assign lvl_v[g] = 1'b0;
      end
      else
      begin : g_bit
         assign lvl_v[g] = lvl_all[POS];
      end
   end

   // raised group first, then lowest index inside the group
   assign hi_req = req_v & lvl_v;
   assign cand = (|hi_req) ? hi_req : req_v;

   ivpm_pick #(
      .N(NS),
      .IW(IW)
   ) u_pick (
      .req(cand),
      .found(found),
      .idx(pick_idx)
   );

   // table holds only assigned vectors
   assign vec_num_c = VEC_TAB[7*int'(pick_idx) +: 7];
   assign addr_c = adv_q ? {15'h0000, vec_num_c, 2'b00} : {16'h0000, vec_num_c, 1'b0};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         vec_q <= '0;
      else if (clk_en)
      begin
         vec_q.valid <= found;
         vec_q.num <= found ? vec_num_c : 7'h00;
         vec_q.addr <= found ? addr_c : 24'h000000;
      end
   end

   assign new_vec_ev = found && (!vec_q.valid || vec_q.num != vec_num_c);
   assign nmi_ev = pin_sync_q[0] && !nmi_prev_q;

   // bus slave: writes zero wait, reads one wait
   assign accept = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_q <= BUS_IDLE;
         hready_q <= 1'b1;
         hresp_q <= 1'b0;
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
      end
      else if (clk_en)
      begin
         hresp_q <= 1'b0;
         wr_pend_q <= accept && hwrite;
         if (accept)
            addr_q <= haddr[7:0];
         case (bus_q)
            BUS_IDLE:
            begin
               if (accept && !hwrite)
               begin
                  bus_q <= BUS_RDWAIT;
                  hready_q <= 1'b0;
               end
            end
            BUS_RDWAIT:
            begin
               hrdata_q <= rd_mux;
               hready_q <= 1'b1;
               bus_q <= BUS_IDLE;
            end
            default:
            begin
               bus_q <= BUS_IDLE;
               hready_q <= 1'b1;
            end
         endcase
      end
   end

   always_comb
   begin
      case (addr_q)
         `IVPM_OFF_LEVEL_A: rd_mux = {24'h000000, lvl_a_q};
         `IVPM_OFF_LEVEL_B: rd_mux = {24'h000000, lvl_b_q};
         `IVPM_OFF_LEVEL_C: rd_mux = {24'h000000, lvl_c_q};
         `IVPM_OFF_CTRL: rd_mux = {31'h00000000, adv_q};
         `IVPM_OFF_STATUS: rd_mux = {30'h00000000, status_q};
         `IVPM_OFF_MASK: rd_mux = {30'h00000000, mask_q};
         `IVPM_OFF_VECTOR: rd_mux = {24'h000000, vec_q.valid, vec_q.num};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvl_a_q <= `IVPM_LVL_RESET;
         lvl_b_q <= `IVPM_LVL_RESET;
         lvl_c_q <= `IVPM_LVL_RESET;
         adv_q <= 1'b0;
         mask_q <= 2'b00;
      end
      else if (clk_en && wr_pend_q)
      begin
         case (addr_q)
            `IVPM_OFF_LEVEL_A: lvl_a_q <= hwdata[7:0];
            `IVPM_OFF_LEVEL_B: lvl_b_q <= hwdata[7:0];
            `IVPM_OFF_LEVEL_C: lvl_c_q <= hwdata[7:0];
            `IVPM_OFF_CTRL: adv_q <= hwdata[`IVPM_CTRL_ADV_BIT];
            `IVPM_OFF_MASK: mask_q <= hwdata[1:0];
            default:
            begin
            end
         endcase
      end
   end

   // sticky events, write one to clear, a new event beats the clear
   always_comb
   begin
      status_d = status_q;
      if (wr_pend_q && addr_q == `IVPM_OFF_STATUS)
         status_d = status_q & ~hwdata[1:0];
      status_d[`IVPM_STAT_NEWVEC_BIT] = status_d[`IVPM_STAT_NEWVEC_BIT] | new_vec_ev;
      status_d[`IVPM_STAT_NMI_BIT] = status_d[`IVPM_STAT_NMI_BIT] | nmi_ev;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status_q <= 2'b00;
         irq_q <= 1'b0;
      end
      else if (clk_en)
      begin
         status_q <= status_d;
         irq_q <= |(status_q & mask_q);
      end
   end

   chk_nmi_first: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && pin_sync_q[0] |=> vec_q.valid && vec_q.num == `IVPM_NMI_VEC)
      else $error("pin nmi did not win");

   chk_lowest_vector: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[1] && lvl_v[1] && !req_v[0] |=> vec_q.num == 7'd16)
      else $error("lowest vector at raised level not chosen");

   chk_level_lifts: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[8] && lvl_v[8] && !(|hi_req[7:0]) |=> vec_q.num == 7'd28)
      else $error("raised converter group did not win");

   chk_group_order: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[18:16] == 3'b110 && req_v[15:0] == 16'h0000
      && !(|hi_req[36:19]) |=> vec_q.num == 7'd65)
      else $error("order inside timer 0 group wrong");

   chk_table_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en ##1 vec_q.valid |-> vec_q.addr == ($past(adv_q)
      ? {15'h0000, vec_q.num, 2'b00} : {16'h0000, vec_q.num, 1'b0}))
      else $error("vector address wrong for mode");

   chk_xfer_end_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v == 37'h10 |=> vec_q.num == 7'd24)
      else $error("transfer end vector wrong");

   chk_break_no_level: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v == 37'h80 && lvl_all == 24'hffffff
      |=> vec_q.num == 7'd27 && vec_q.valid)
      else $error("address break vector wrong");

   chk_no_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
      vec_q.valid |-> !(vec_q.num inside {[0:6], [8:15], [19:23], [29:47], [55:63],
      67, 71, [76:79], [88:91], [95:127]}))
      else $error("reserved vector produced");

   chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en |=> irq_q == |($past(status_q) & $past(mask_q)))
      else $error("interrupt output does not follow status and mask");

   chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && accept && !hwrite |=> !hready_q ##1 (hready_q || !clk_en))
      else $error("read answer timing wrong");

   chk_converter_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v == 37'h100 |=> vec_q.valid && vec_q.num == 7'd28)
      else $error("converter vector wrong");

   chk_frt_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[15:0] == 16'h8000 && !(|hi_req[36:16]) |=> vec_q.num == 7'd54)
      else $error("free timer overflow vector wrong");

   chk_tmr0_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[18:0] == 19'h40000 && !(|hi_req[36:19]) |=> vec_q.num == 7'd66)
      else $error("timer 0 overflow vector wrong");

   chk_tmr1_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[21:0] == 22'h080000 && !(|hi_req[36:20]) |=> vec_q.num == 7'd68)
      else $error("timer 1 match vector wrong");

   chk_tmrxy_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[25:0] == 26'h2000000 && !(|hi_req[36:26]) |=> vec_q.num == 7'd75)
      else $error("timer x capture vector wrong");

   chk_ser0_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[26:0] == 27'h4000000 && !(|hi_req[36:27]) |=> vec_q.num == 7'd80)
      else $error("serial 0 error vector wrong");

   chk_ser1_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[33:0] == 34'h200000000 && !(|hi_req[36:34]) |=> vec_q.num == 7'd87)
      else $error("serial 1 end vector wrong");

   chk_pin_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[3:0] == 4'h8 && !(|hi_req[36:4]) |=> vec_q.num == 7'd18)
      else $error("pin request 2 vector wrong");

   chk_wdog_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v[6:0] == 7'h40 && !(|hi_req[36:7]) |=> vec_q.num == 7'd26)
      else $error("watchdog 1 vector wrong");

   chk_twowire_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && req_v == 37'h1000000000 |=> vec_q.valid && vec_q.num == 7'd94)
      else $error("two-wire 1 vector wrong");

   chk_status_set: assert property (@(posedge hclk) disable iff (!hresetn)
      clk_en && new_vec_ev |=> status_q[`IVPM_STAT_NEWVEC_BIT])
      else $error("new vector event not recorded");

   cov_nmi: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && pin_sync_q[0] && |req_v[36:1]);
   cov_raised_win: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && |hi_req[36:1] && |(req_v & ~lvl_v));
   cov_advanced: cover property (@(posedge hclk) disable iff (!hresetn)
      vec_q.valid && adv_q && irq_q);
   cov_frozen: cover property (@(posedge hclk) disable iff (!hresetn)
      !clk_en && found);
   cov_nmi_event: cover property (@(posedge hclk) disable iff (!hresetn)
      clk_en && nmi_ev);

endmodule : ivpm_top
`default_nettype wire

// ===== verification/ivpm_cpu_model.sv
// cpu core stand-in that takes presented vectors
`default_nettype none
module ivpm_cpu_model
   import ivpm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire ivpm_vec_type vec_in,
   input wire logic irq,
   output ivpm_vec_type taken_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // takes the vector only while the interrupt line is raised
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         taken_q <= '0;
      end
      else if (irq && vec_in.valid)
      begin
         taken_q <= vec_in;
      end
   end
endmodule : ivpm_cpu_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench for the interrupt vector priority map
`default_nettype none
module testbench
   import ivpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nmi_pin, irq, m, ce;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] irq_pin;
   logic [23:0] lv;
   logic [36:0] r;
   ivpm_req_type periph_req;
   ivpm_vec_type vec_out, taken;
   int n_fail, check_count;
   // vector and level bit per source, in default order; -1 means no level bit
   localparam int VEC[37] = '{7, 16, 17, 18, 24, 25, 26, 27, 28, 48, 49, 50, 51, 52, 53, 54,
      64, 65, 66, 68, 69, 70, 72, 73, 74, 75, 80, 81, 82, 83, 84, 85, 86, 87, 92, 93, 94};
   localparam int LVL[37] = '{-1, 7, 6, 5, 2, 1, 0, -1, 15, 14, 14, 14, 14, 14, 14, 14,
      11, 11, 11, 10, 10, 10, 9, 9, 9, 9, 23, 23, 23, 23, 22, 22, 22, 22, 20, 20, 19};

   ivpm_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nmi_pin(nmi_pin),
      .irq_pin(irq_pin), .periph_req(periph_req), .vec_out(vec_out), .irq(irq));
   ivpm_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .vec_in(vec_out), .irq(irq),
      .taken_q(taken));

   initial
   begin
      hclk = 1'h0;
      forever #10 hclk = ~hclk;
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'h1 && k < 20);
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : wait_rdy

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task set_lv(input logic [23:0] l, input logic md);
      lv = l;
      m = md;
      bus(1'h1, 8'h00, {24'h0, l[7:0]});
      bus(1'h1, 8'h04, {24'h0, l[15:8]});
      bus(1'h1, 8'h08, {24'h0, l[23:16]});
      bus(1'h1, 8'h0c, {31'h0, md});
   endtask : set_lv

   task drive(input logic [36:0] q);
      nmi_pin <= q[0];
      irq_pin <= q[3:1];
      periph_req <= q[36:4];
      repeat (5) @(posedge hclk);
   endtask : drive

   // nmi first, then lifted groups, then plain default order
   function automatic logic [31:0] model(logic [36:0] q, logic [23:0] l, logic md);
      int b;
      int n;
      b = q[0] ? 0 : -1;
      for (int i = 1; i < 37; i++)
         if (b < 0 && q[i] && LVL[i] >= 0 && l[LVL[i]]) b = i;
      for (int i = 1; i < 37; i++)
         if (b < 0 && q[i]) b = i;
      if (b < 0) return 32'h0;
      n = VEC[b];
      return {1'h1, n[6:0], 24'(md ? n * 4 : n * 2)};
   endfunction : model

   task wrap_up;
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      #1000000;
      n_fail++;
      wrap_up();
   end

   initial
   begin
      n_fail = 0;
      check_count = 0;
      hresetn = 1'h0;
      hsel = 1'h0;
      hwrite = 1'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      nmi_pin = 1'h0;
      irq_pin = 3'h0;
      periph_req = '0;
      lv = 24'h0;
      m = 1'h0;
      ce = 1'h1;
      rd = $urandom(42812);
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      chk("vec_rst", 32'h0, vec_out);
      // reset values, unmapped 0x1c and 0x20 included
      for (int a = 0; a < 36; a += 4)
      begin
         bus(1'h0, 8'(a), 32'h0);
         chk("reset_read", 32'h0, rd);
      end
      for (int md = 0; md < 2; md++)
      begin
         set_lv(24'h0, md[0]);
         for (int i = 0; i < 37; i++)
         begin
            r = 37'h1 << i;
            drive(r);
            chk("one", model(r, lv, m), vec_out);
            drive(37'h0);
         end
      end
      for (int t = 0; t < 300; t++)
      begin
         set_lv(24'($urandom), 1'($urandom));
         r = 37'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom});
         drive(r);
         chk("mix", model(r, lv, m), vec_out);
      end
      drive(37'h0);
      set_lv(24'h008000, 1'h0);
      bus(1'h1, 8'h10, 32'h3);
      bus(1'h1, 8'h14, 32'h1);
      drive(37'h1 << 8);
      chk("irq_on", 32'h1, {31'h0, irq});
      chk("cpu_vec", {1'h1, 7'h1c, 24'h38}, taken);
      bus(1'h0, 8'h18, 32'h0);
      chk("vec_reg", 32'h9c, rd);
      bus(1'h0, 8'h10, 32'h0);
      chk("status", 32'h1, rd & 32'h1);
      bus(1'h1, 8'h14, 32'h0);
      repeat (2) @(posedge hclk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'h1, 8'h14, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq_unmasked", 32'h1, {31'h0, irq});
      bus(1'h1, 8'h10, 32'h1);
      repeat (2) @(posedge hclk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      bus(1'h0, 8'h10, 32'h0);
      chk("status_clr", 32'h0, rd & 32'h3);
      // enable low must freeze the presented vector
      ce <= 1'h0;
      drive(37'h1 << 4);
      chk("ce_hold", {1'h1, 7'h1c, 24'h38}, vec_out);
      ce <= 1'h1;
      drive(37'h11);
      chk("nmi_vec", model(37'h11, lv, m), vec_out);
      bus(1'h0, 8'h10, 32'h0);
      chk("status_nmi", 32'h2, rd & 32'h2);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
